// *** rtl/cls_top.sv ***
// register side of the codec link command slots, with axi4-lite slave
// assumes a codec driving bit clock and serial data on the link pins
`timescale 1ns/1ps
`default_nettype none
module cls_top
    import cls_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic [31:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [31:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        codec_bit_clk_in,
    input  wire logic        codec_sdata_in,
    output logic             codec_sync_out,
    output logic             codec_sdata_out
);
    typedef struct packed {
        logic [4:0]  tag_out;
        logic [7:0]  cmd;
        logic [15:0] wdata;
        logic [4:0]  tag_in;
        logic [15:0] rdata_in;
        logic        pend;
        logic        rrdy;
        logic        frame_cmd;
        logic        read_sent;
        logic        read_expect;
        logic [6:0]  sent_idx;
        logic [6:0]  expect_idx;
        logic [15:0] tx_tag;
        logic [19:0] tx_s1;
        logic [19:0] tx_s2;
        logic        aw_got;
        logic        w_got;
        logic [31:0] awaddr;
        logic [31:0] wbuf;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cls_top_s;

    cls_top_s    s_q, s_d;
    logic        fend, rxdone;
    logic [15:0] rx_tag;
    logic [19:0] rx_s1, rx_s2;

    // -----------------------------------------------------------------
    // byte-lane merge of a write
    // -----------------------------------------------------------------
    function automatic logic [31:0] cls_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : cls_merge

    // -----------------------------------------------------------------
    // serial frame engine
    // -----------------------------------------------------------------
    cls_link u_link (
        .clk_sys_in    (clk_sys_in),
        .resetn_in     (resetn_in),
        .bit_clk_in    (codec_bit_clk_in),
        .sdata_in      (codec_sdata_in),
        .tx_tag_in     (s_q.tx_tag),
        .tx_s1_in      (s_q.tx_s1),
        .tx_s2_in      (s_q.tx_s2),
        .sync_out      (codec_sync_out),
        .sdata_out     (codec_sdata_out),
        .frame_end_out (fend),
        .rx_done_out   (rxdone),
        .rx_tag_out    (rx_tag),
        .rx_s1_out     (rx_s1),
        .rx_s2_out     (rx_s2)
    );

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [31:0] m;
        logic        go;
        m   = 32'h0000_0000;
        go  = 1'b0;
        s_d = s_q;
        // write channel capture, either order
        if (s_axi_awvalid_in && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wbuf  = s_axi_wdata_in;
            s_d.wstrb = s_axi_wstrb_in;
        end
        if (s_q.bvalid && s_axi_bready_in) begin
            s_d.bvalid = 1'b0;
        end
        // frame boundary: a pending command rides exactly one frame
        if (fend) begin
            go              = s_q.pend & ~s_q.frame_cmd;
            s_d.pend        = go;
            s_d.read_expect = s_q.read_sent;
            s_d.expect_idx  = s_q.sent_idx;
            s_d.frame_cmd   = go;
            s_d.read_sent   = go & s_q.cmd[CLS_RW_BIT];
            s_d.sent_idx    = s_q.cmd[6:0];
            s_d.tx_tag      = {s_q.tag_out[4], s_q.tag_out[0] & go,
                               s_q.tag_out[1] & go,
                               s_q.tag_out[2], s_q.tag_out[3], 11'h000};
            s_d.tx_s1       = go ? {s_q.cmd, 12'h000}
                                 : 20'h0_0000;
            s_d.tx_s2       = (go && !s_q.cmd[CLS_RW_BIT])
                              ? {s_q.wdata, 4'h0}
                              : 20'h0_0000;
        end
        // register write once address and data are both in
        if (s_d.aw_got && s_d.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = CLS_RESP_OKAY;
            unique case (s_d.awaddr)
                CLS_TAG_OUT_OFS: begin
                    m = cls_merge({27'h0, s_q.tag_out}, s_d.wbuf, s_d.wstrb);
                    if (!s_q.pend) begin
                        s_d.tag_out = m[4:0];
                        s_d.pend    = 1'b1;
                    end
                end
                CLS_CMD_OFS: begin
                    m = cls_merge({24'h0, s_q.cmd}, s_d.wbuf, s_d.wstrb);
                    s_d.cmd = m[7:0];
                end
                CLS_WDATA_OFS: begin
                    m = cls_merge({16'h0, s_q.wdata}, s_d.wbuf, s_d.wstrb);
                    s_d.wdata = m[15:0];
                end
                CLS_TAG_IN_OFS, CLS_RDATA_IN_OFS, CLS_STATUS_OFS: begin
                    s_d.bresp = CLS_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = CLS_RESP_SLVERR;
                end
            endcase
        end
        // read channel
        if (s_q.rvalid && s_axi_rready_in) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = CLS_RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr_in)
                CLS_TAG_OUT_OFS:  s_d.rdata = {27'h0, s_q.tag_out};
                CLS_CMD_OFS:      s_d.rdata = {24'h0, s_q.cmd};
                CLS_WDATA_OFS:    s_d.rdata = {16'h0, s_q.wdata};
                CLS_TAG_IN_OFS:   s_d.rdata = {27'h0, s_q.tag_in};
                CLS_RDATA_IN_OFS: begin
                    s_d.rdata = {16'h0, s_q.rdata_in};
                    s_d.rrdy  = 1'b0;
                end
                CLS_STATUS_OFS:   s_d.rdata = {30'h0, s_q.rrdy, s_q.pend};
                default:          s_d.rresp = CLS_RESP_SLVERR;
            endcase
        end
        // incoming slots; a capture wins over a same-cycle clear
        if (rxdone) begin
            s_d.tag_in = {rx_tag[15], rx_tag[11], rx_tag[12], rx_tag[13],
                          rx_tag[14]};
            if (s_q.read_expect && rx_tag[13]
                && rx_s1[18:12] == s_q.expect_idx) begin
                s_d.rdata_in = rx_s2[19:4];
                s_d.rrdy     = 1'b1;
            end
        end
        s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_got & ~s_d.bvalid;
        s_d.arready = ~s_d.rvalid;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_q         <= '0;
            s_q.cmd     <= CLS_CMD_RST;
            s_q.wdata   <= CLS_WDATA_RST;
            s_q.tag_in  <= CLS_TAG_RST;
            s_q.tag_out <= CLS_TAG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_out = s_q.awready;
    assign s_axi_wready_out  = s_q.wready;
    assign s_axi_bvalid_out  = s_q.bvalid;
    assign s_axi_bresp_out   = s_q.bresp;
    assign s_axi_arready_out = s_q.arready;
    assign s_axi_rvalid_out  = s_q.rvalid;
    assign s_axi_rdata_out   = s_q.rdata;
    assign s_axi_rresp_out   = s_q.rresp;
endmodule : cls_top
`default_nettype wire

// *** rtl/cls_pkg.sv ***
// constants of the codec link command slot block
// assumes a 200 MHz system clock and a codec that clocks the link
package cls_pkg;
    // -----------------------------------------------------------------
    // register byte addresses
    // -----------------------------------------------------------------
    localparam logic [31:0] CLS_TAG_OUT_OFS  = 32'hfff0_9030;
    localparam logic [31:0] CLS_CMD_OFS      = 32'hfff0_9034;
    localparam logic [31:0] CLS_WDATA_OFS    = 32'hfff0_9038;
    localparam logic [31:0] CLS_TAG_IN_OFS   = 32'hfff0_903c;
    localparam logic [31:0] CLS_RDATA_IN_OFS = 32'hfff0_9044;
    localparam logic [31:0] CLS_STATUS_OFS   = 32'hfff0_9048;
    // -----------------------------------------------------------------
    // reset values and fields
    // -----------------------------------------------------------------
    localparam logic [7:0]  CLS_CMD_RST      = 8'h80;
    localparam logic [15:0] CLS_WDATA_RST    = 16'h0000;
    localparam logic [4:0]  CLS_TAG_RST      = 5'h00;
    localparam int          CLS_RW_BIT       = 7;
    localparam int          CLS_READY_BIT    = 4;
    localparam int          CLS_ST_PEND_BIT  = 0;
    localparam int          CLS_ST_RRDY_BIT  = 1;
    // -----------------------------------------------------------------
    // frame bit positions, counted from the first tag bit
    // -----------------------------------------------------------------
    localparam logic [7:0]  CLS_TAG_LAST     = 8'd15;
    localparam logic [7:0]  CLS_S1_LAST      = 8'd35;
    localparam logic [7:0]  CLS_S2_LAST      = 8'd55;
    localparam logic [7:0]  CLS_FRAME_LAST   = 8'd255;
    // -----------------------------------------------------------------
    // bus answers
    // -----------------------------------------------------------------
    localparam logic [1:0]  CLS_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  CLS_RESP_SLVERR  = 2'b10;
endpackage : cls_pkg

// *** rtl/cls_link.sv ***
// serial frame engine of the codec link
// assumes bit clock and serial input come straight from pins
`timescale 1ns/1ps
`default_nettype none
module cls_link
    import cls_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        bit_clk_in,
    input  wire logic        sdata_in,
    input  wire logic [15:0] tx_tag_in,
    input  wire logic [19:0] tx_s1_in,
    input  wire logic [19:0] tx_s2_in,
    output logic             sync_out,
    output logic             sdata_out,
    output logic             frame_end_out,
    output logic             rx_done_out,
    output logic [15:0]      rx_tag_out,
    output logic [19:0]      rx_s1_out,
    output logic [19:0]      rx_s2_out
);
    typedef struct packed {
        logic        bclk_m;
        logic        bclk_s;
        logic        bclk_p;
        logic        din_m;
        logic        din_s;
        logic [7:0]  cnt;
        logic [19:0] sh;
        logic [15:0] tag;
        logic [19:0] s1;
        logic [19:0] s2;
        logic        sync;
        logic        dout;
        logic        fend;
        logic        rxdone;
    } cls_link_s;

    cls_link_s s_q, s_d;
    logic      rise, fall;
    logic [7:0] nxt;

    // -----------------------------------------------------------------
    // outgoing bit for a frame position
    // -----------------------------------------------------------------
    function automatic logic cls_tx_bit(input logic [7:0]  pos,
                                        input logic [15:0] tag,
                                        input logic [19:0] s1,
                                        input logic [19:0] s2);
        logic [7:0] idx;
        idx = 8'h00;
        if (pos <= CLS_TAG_LAST) begin
            idx = CLS_TAG_LAST - pos;
            return tag[idx[3:0]];
        end else if (pos <= CLS_S1_LAST) begin
            idx = CLS_S1_LAST - pos;
            return s1[idx[4:0]];
        end else if (pos <= CLS_S2_LAST) begin
            idx = CLS_S2_LAST - pos;
            return s2[idx[4:0]];
        end
        return 1'b0;
    endfunction : cls_tx_bit

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.fend   = 1'b0;
        s_d.rxdone = 1'b0;
        s_d.bclk_m = bit_clk_in;
        s_d.bclk_s = s_q.bclk_m;
        s_d.bclk_p = s_q.bclk_s;
        s_d.din_m  = sdata_in;
        s_d.din_s  = s_q.din_m;
        rise       = s_q.bclk_s & ~s_q.bclk_p;
        fall       = ~s_q.bclk_s & s_q.bclk_p;
        nxt        = s_q.cnt + 8'd1;
        if (rise) begin
            s_d.cnt  = nxt;
            s_d.sync = (nxt <= CLS_TAG_LAST);
            s_d.dout = cls_tx_bit(nxt, tx_tag_in, tx_s1_in,
                                  tx_s2_in);
        end
        if (fall) begin
            s_d.sh = {s_q.sh[18:0], s_q.din_s};
            if (s_q.cnt == CLS_TAG_LAST) begin
                s_d.tag = {s_q.sh[14:0], s_q.din_s};
            end
            if (s_q.cnt == CLS_S1_LAST) begin
                s_d.s1 = {s_q.sh[18:0], s_q.din_s};
            end
            if (s_q.cnt == CLS_S2_LAST) begin
                s_d.s2     = {s_q.sh[18:0], s_q.din_s};
                s_d.rxdone = 1'b1;
            end
            if (s_q.cnt == CLS_FRAME_LAST) begin
                s_d.fend = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_q     <= '0;
            s_q.cnt <= CLS_FRAME_LAST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out      = s_q.sync;
    assign sdata_out     = s_q.dout;
    assign frame_end_out = s_q.fend;
    assign rx_done_out   = s_q.rxdone;
    assign rx_tag_out    = s_q.tag;
    assign rx_s1_out     = s_q.s1;
    assign rx_s2_out     = s_q.s2;
endmodule : cls_link
`default_nettype wire

// *** bench/cls_top_props.sv ***
// checker for the codec link command slot block
// assumes binding onto cls_top and a link bit clock of 80 ns
`timescale 1ns/1ps
`default_nettype none
module cls_props
    import cls_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        resetn_in,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic        codec_sync_out,
    input wire logic        codec_sdata_out
);
    // ------------------------------------------------------------
    // frame counters and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic [11:0] hi_q;
    logic [11:0] fr_q;
    logic        sy_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hi_q <= 12'h000;
            fr_q <= 12'hfff;
            sy_q <= 1'b0;
        end else begin
            hi_q <= codec_sync_out ? hi_q + 12'h001 : 12'h000;
            sy_q <= codec_sync_out;
            fr_q <= (codec_sync_out && !sy_q) ? 12'h000 :
                    (fr_q == 12'hfff) ? fr_q : fr_q + 12'h001;
        end
    end
    property p_aw_take;
        s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out;
    endproperty
    a_aw_take: assert property (p_aw_take) else $error("awready stayed");
    property p_b_rise;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |=> s_axi_bvalid_out;
    endproperty
    a_b_rise: assert property (p_b_rise) else $error("no bvalid");
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid lost");
    property p_r_rise;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_r_rise: assert property (p_r_rise) else $error("no rvalid");
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid lost");
    property p_ar_blk;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    a_ar_blk: assert property (p_ar_blk) else $error("arready early");
    property p_okay;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out && s_axi_awaddr_in == CLS_CMD_OFS
        |=> s_axi_bresp_out == CLS_RESP_OKAY;
    endproperty
    a_okay: assert property (p_okay) else $error("bad bresp");
    property p_sync_len;
        $fell(codec_sync_out) |-> hi_q >= 12'd250 && hi_q <= 12'd262;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync len");
    property p_pad;
        fr_q >= 12'd920 && fr_q <= 12'd4000 |-> !codec_sdata_out;
    endproperty
    a_pad: assert property (p_pad) else $error("pad not zero");
    c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
    c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
    c_fr: cover property ($fell(codec_sync_out));
endmodule : cls_props
`default_nettype wire

// *** bench/cls_codec_model.sv ***
// behavioural audio codec on the far side of the serial link
// assumes the device samples on falling and drives on rising bit clock
`timescale 1ns/1ps
`default_nettype none
module cls_codec_model (
    input  wire logic [4:0]  tag_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        sync_in,
    input  wire logic        sdata_in,
    output logic             bit_clk_out,
    output logic             sdata_out,
    output logic [55:0]      tx_out
);
    // ------------------------------------------------------------
    // bit clock, frame build and capture
    // ------------------------------------------------------------
    logic [7:0]  pos;
    logic [55:0] sh;
    logic [55:0] fr;
    logic        rd_q;
    logic [6:0]  ix_q;
    initial begin
        bit_clk_out = 1'b0;
        sdata_out = 1'b0;
        pos = 8'hc8;
        {sh, fr, tx_out, rd_q, ix_q} = '0;
        #13;
        forever #40 bit_clk_out = ~bit_clk_out;
    end
    always @(posedge bit_clk_out) begin
        pos = pos + 8'h01;
        sdata_out = (pos < 8'h38) ? fr[8'h37 - pos] : pos[0];
    end
    // new frame on sync, echo of last frame's read
    always @(posedge sync_in) begin
        pos = 8'h00;
        fr = {tag_in[4], tag_in[0] | rd_q, tag_in[1] | rd_q, tag_in[2],
              tag_in[3], 11'h000, 1'b0, ix_q, 12'h000, rdata_in, 4'h0};
        sdata_out = fr[55];
    end
    always @(negedge bit_clk_out) begin
        if (pos < 8'h38) sh = {sh[54:0], sdata_in};
        if (pos == 8'h37) begin
            tx_out = sh;
            rd_q = sh[54] && sh[39];
            ix_q = sh[38:32];
        end
    end
endmodule : cls_codec_model
`default_nettype wire

// *** bench/cls_top_tb_top.sv ***
// self-checking bench for the codec link command slot block
// assumes the behavioural codec model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cls_top_tb_top
    import cls_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus, bus tasks and checks
    // ------------------------------------------------------------
    logic        clk_sys, resetn, aw_v, w_v, b_r, ar_v, r_r;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, bclk, sd_in, sync, sd_out;
    logic [31:0] aw_a, w_d, ar_a, r_d, d_q, v;
    logic [1:0]  b_rsp, r_rsp, rsp_q;
    logic [4:0]  tag_c;
    logic [3:0]  w_s;
    logic [15:0] rdat_c;
    logic [55:0] tx;
    int          failures, tests_run, seed, lag;
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    cls_top cls_top_i (.clk_sys_in(clk_sys), .resetn_in(resetn),
        .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
        .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_d),
        .s_axi_wstrb_in(w_s), .s_axi_wvalid_in(w_v),
        .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_rsp),
        .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
        .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
        .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d),
        .s_axi_rresp_out(r_rsp), .s_axi_rvalid_out(r_v),
        .s_axi_rready_in(r_r),
        .codec_bit_clk_in(bclk), .codec_sdata_in(sd_in),
        .codec_sync_out(sync), .codec_sdata_out(sd_out));
    cls_codec_model cls_codec_model_i (.tag_in(tag_c), .rdata_in(rdat_c),
        .sync_in(sync), .sdata_in(sd_out), .bit_clk_out(bclk),
        .sdata_out(sd_in), .tx_out(tx));
    task automatic results;
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic axw(input logic [31:0] a, d);
        int n;
        n = 0;
        lag = $unsigned($random(seed)) % 4;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= (lag == 0);
        do begin
            @(posedge clk_sys);
            n++;
            if (aw_v && aw_rdy) aw_v <= 1'b0;
            if (w_v && w_rdy) w_v <= 1'b0;
            if (n == lag) b_r <= 1'b1;
        end while (!(b_v && b_r));
        rsp_q = b_rsp;
    endtask : axw
    task automatic axr(input logic [31:0] a);
        int n;
        n = 0;
        lag = $unsigned($random(seed)) % 4;
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= (lag == 0);
        do begin
            @(posedge clk_sys);
            n++;
            if (ar_v && ar_rdy) ar_v <= 1'b0;
            if (n == lag) r_r <= 1'b1;
        end while (!(r_v && r_r));
        d_q = r_d;
        rsp_q = r_rsp;
    endtask : axr
    task automatic rc(input logic [31:0] a, e, input string nm);
        axr(a);
        chk(nm, e, d_q);
        chk("rresp", {30'h0, CLS_RESP_OKAY}, {30'h0, rsp_q});
    endtask : rc
    function automatic logic [31:0] exp_s1(input logic       rw,
                                           input logic [6:0] ix);
        return {12'h0, rw, ix, 12'h000};
    endfunction : exp_s1
    task automatic cmd(input logic rw, input logic [6:0] ix,
                       input logic [15:0] wd);
        axw(CLS_CMD_OFS, {24'h0, rw, ix});
        axw(CLS_WDATA_OFS, {16'h0, wd});
        axw(CLS_TAG_OUT_OFS, 32'h0000_0013);
        axr(CLS_STATUS_OFS);
        chk("pending", 32'h1, {31'h0, d_q[0]});
        do axr(CLS_STATUS_OFS); while (d_q[0]);
        chk("slot1", exp_s1(rw, ix), {12'h0, tx[39:20]});
        chk("tag out", 32'h7, {29'h0, tx[55:53]});
        if (!rw) chk("slot2", {12'h0, wd, 4'h0}, {12'h0, tx[19:0]});
    endtask : cmd
    initial begin
        seed = 67536;
        failures = 0;
        tests_run = 0;
        {resetn, aw_v, w_v, b_r, ar_v, r_r, aw_a, w_d, ar_a} = '0;
        tag_c = 5'h00;
        w_s = 4'hf;
        rdat_c = 16'h0000;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rc(CLS_CMD_OFS, 32'h0000_0080, "command reset");
        rc(CLS_WDATA_OFS, 32'h0, "write data reset");
        rc(CLS_TAG_IN_OFS, 32'h0, "tag in reset");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            axw(CLS_CMD_OFS, v);
            chk("bresp", {30'h0, CLS_RESP_OKAY}, {30'h0, rsp_q});
            rc(CLS_CMD_OFS, {24'h0, v[7:0]}, "command");
            axw(CLS_WDATA_OFS, v);
            rc(CLS_WDATA_OFS, {16'h0, v[15:0]}, "write data");
        end
        w_s <= 4'he;
        axw(CLS_CMD_OFS, ~v);
        w_s <= 4'hf;
        rc(CLS_CMD_OFS, {24'h0, v[7:0]}, "strobed command");
        axw(32'hfff0_9000, v);
        chk("wr resp", {30'h0, CLS_RESP_SLVERR}, {30'h0, rsp_q});
        axw(CLS_TAG_IN_OFS, 32'hffff_ffff);
        rc(CLS_TAG_IN_OFS, 32'h0, "tag in");
        axr(32'hfff0_9000);
        chk("unmapped", {30'h0, CLS_RESP_SLVERR}, {30'h0, rsp_q});
        v = $random(seed);
        cmd(1'b0, 7'h7f, v[15:0]);
        cmd(1'b0, v[22:16], 16'hffff);
        rdat_c <= v[31:16];
        cmd(1'b1, v[6:0], v[15:0]);
        do axr(CLS_STATUS_OFS); while (!d_q[1]);
        rc(CLS_RDATA_IN_OFS, {16'h0, rdat_c}, "read data");
        rc(CLS_STATUS_OFS, 32'h0, "status");
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            tag_c <= (i == 0) ? 5'h10 : (i == 1) ? 5'h0f : v[4:0];
            repeat (8200) @(posedge clk_sys);
            rc(CLS_TAG_IN_OFS, {27'h0, tag_c}, "tag in");
        end
        results();
    end
    initial begin
        #450000;
        failures++;
        results();
    end
endmodule : cls_top_tb_top
bind cls_top cls_props cls_props_i (.*);
`default_nettype wire
